// [rtl/cfc_cfg.svh]
`ifndef CFC_CFG_SVH
`define CFC_CFG_SVH
// ============================================================
// Frame layout
`define CFC_FRAME_BITS 112
`define CFC_F_CMD 111:109
`define CFC_F_SRC 108:101
`define CFC_F_BC 100
`define CFC_F_DST 99:92
`define CFC_F_PAY 88:1
`define CFC_CMD_PPS 3'h0
`define CFC_CMD_SYNC 3'h3
`define CFC_CMD_READ 3'h2
`define CFC_CMD_WRITE 3'h4
`define CFC_CMD_USER 3'h7
`define CFC_UBLK 128
// ============================================================
// Register offsets
`define CFC_A_CTRL 8'h00
`define CFC_A_IDS 8'h04
`define CFC_A_TXP0 8'h08
`define CFC_A_TXP1 8'h0C
`define CFC_A_TXP2 8'h10
`define CFC_A_TXCMD 8'h14
`define CFC_A_STAT 8'h18
`define CFC_A_UTX 8'h1C
`define CFC_A_RXH 8'h20
`define CFC_A_RXP0 8'h24
`define CFC_A_RXP1 8'h28
`define CFC_A_RXP2 8'h2C
`define CFC_A_URX 8'h30
// ============================================================
// Reset values and timing
`define CFC_CTRL_RST 32'h0000_0000
`define CFC_IDS_RST 24'h00_0000
`define CFC_PCLK_NS 8
`endif

// [rtl/cfc_pkg.sv]
// ============================================================
// Types shared by the codec
package cfc_pkg;
  typedef enum logic [1:0] {
    CFC_SYM_SPACE = 2'h0,
    CFC_SYM_ZERO = 2'h1,
    CFC_SYM_ONE = 2'h3
  } cfc_sym_e;
  typedef enum logic [1:0] {
    CFC_TX_IDLE = 2'h0,
    CFC_TX_LOAD = 2'h1,
    CFC_TX_SEND = 2'h3
  } cfc_tx_e;
  typedef enum logic [2:0] {
    CFC_K_PPS = 3'h0,
    CFC_K_SYNC = 3'h1,
    CFC_K_CMD = 3'h3,
    CFC_K_REP = 3'h2,
    CFC_K_USER = 3'h6
  } cfc_kind_e;
  // Bytes carried by one user frame, at most nine
  function automatic logic [3:0] cfc_min9(input logic [7:0] n);
    cfc_min9 = (n > 8'h09) ? 4'h9 : n[3:0];
  endfunction : cfc_min9
endpackage : cfc_pkg

// [rtl/cfc_pwm_tx.sv]
`timescale 1ns/1ps
module cfc_pwm_tx import cfc_pkg::*; #(parameter int CW = 16) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Carrier edge and symbol
  input wire logic rise,
  input wire cfc_sym_e sym,
  // Modulated carrier
  output logic pwm_q
);
  logic [CW-1:0] cnt_q, per_q, thr_q, q4;
  logic [1:0] seen_q;
  assign q4 = per_q >> 2;
  // ============================================================
  // Carrier period measured between rising edges; pulses stay off until
  // one whole period is known, so the far decoder sees no false symbol
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
      per_q <= '0;
      seen_q <= 2'h0;
    end else if (ce) begin
      if (rise) begin
        per_q <= cnt_q + 1'b1;
        if (!seen_q[1]) seen_q <= seen_q + 2'h1;
        cnt_q <= '0;
      end else if (cnt_q != '1) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end
  // ============================================================
  // falling edge placement
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thr_q <= '0;
      pwm_q <= 1'b0;
    end else if (ce) begin
      if (rise) begin
        pwm_q <= seen_q[1];
        case (sym)
          CFC_SYM_ZERO: thr_q <= (q4 == '0) ? CW'(1) : q4;
          CFC_SYM_ONE: thr_q <= per_q - q4;
          default: thr_q <= per_q >> 1;
        endcase
      end else if (cnt_q + 1'b1 >= thr_q) begin
        pwm_q <= 1'b0;
      end
    end
  end
endmodule : cfc_pwm_tx

// [rtl/cfc_pwm_rx.sv]
`timescale 1ns/1ps
module cfc_pwm_rx import cfc_pkg::*; #(parameter int CW = 16) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Synchronised carrier level
  input wire logic lvl,
  // Decoded symbols
  output logic sym_v_q,
  output cfc_sym_e sym_q
);
  logic lvl_q, primed_q;
  logic [CW-1:0] cnt_q, hi_q;
  logic [CW+2:0] h8, p3, p5;
  assign h8 = {hi_q, 3'b000};
  assign p3 = {2'b00, cnt_q, 1'b0} + (CW+3)'(cnt_q);
  assign p5 = {1'b0, cnt_q, 2'b00} + (CW+3)'(cnt_q);
  // ============================================================
  // high time against period, thresholds at 3/8 and 5/8
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_q <= 1'b0;
      primed_q <= 1'b0;
      cnt_q <= '0;
      hi_q <= '0;
      sym_v_q <= 1'b0;
      sym_q <= CFC_SYM_SPACE;
    end else if (ce) begin
      lvl_q <= lvl;
      sym_v_q <= 1'b0;
      if (lvl && !lvl_q) begin
        primed_q <= 1'b1;
        sym_v_q <= primed_q;
        if (h8 < p3) sym_q <= CFC_SYM_ZERO;
        else if (h8 > p5) sym_q <= CFC_SYM_ONE;
        else sym_q <= CFC_SYM_SPACE;
        cnt_q <= '0;
        hi_q <= CW'(1);
      end else begin
        if (cnt_q != '1) cnt_q <= cnt_q + 1'b1;
        if (lvl && hi_q != '1) hi_q <= hi_q + 1'b1;
      end
    end
  end
endmodule : cfc_pwm_rx

// [rtl/cfc_top.sv]
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/1ps
`include "cfc_cfg.svh"
module cfc_top import cfc_pkg::*; #(parameter int CW = 16) (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Carrier pins
  input wire logic carrier_in,
  output logic pwm_out,
  input wire logic pwm_rx_in,
  // Time sources
  input wire logic [3:0] second_pulse,
  input wire logic alt_second_pulse,
  input wire logic [87:0] tod_value,
  output logic [1:0] tod_src_sel,
  // Sync sources
  input wire logic sync_req,
  input wire logic [87:0] sync_data,
  output logic [2:0] sync_src_sel,
  // Received time and sync data
  output logic [87:0] rx_data,
  output logic tod_load_valid,
  output logic [1:0] tod_load_sel,
  output logic sync_load_valid,
  output logic [2:0] sync_load_sel,
  output logic rx_second_pulse,
  // Local register access from the far end
  output logic csr_req,
  output logic csr_we,
  output logic [15:0] csr_addr,
  output logic [71:0] csr_wdata,
  input wire logic csr_ack,
  input wire logic [71:0] csr_rdata
);
  if (CW < 6) begin : g_chk
    $error("cfc_top: CW too small for carrier period");
  end
  // ============================================================
  // Registers and state
  logic [31:0] ctrl_q;
  logic [23:0] ids_q;
  logic [87:0] txp_q, rep_pay_q, rxp_q, ubytes_q, rx_data_q;
  logic [2:0] cmd_q, rep_cmd_q;
  logic [7:0] rep_dst_q, ulen_q, usent_q, ucnt_q;
  logic [22:0] rxh_q;
  logic cmd_pend_q, rep_pend_q, pps_pend_q, sync_pend_q, usr_pend_q;
  logic rx_new_q, perr_q, pready_q, pslverr_q;
  logic [31:0] prdata_q;
  logic [15:0] pps_cnt_q;
  logic [7:0] utx_mem [0:`CFC_UBLK-1];
  logic [7:0] urx_mem [0:`CFC_UBLK-1];
  logic [6:0] urw_q, urr_q;
  cfc_tx_e st_q;
  cfc_kind_e kind_q;
  logic [3:0] lcnt_q, un, ux_n_q, ux_k_q;
  logic [6:0] bcnt_q, rcnt_q;
  logic [111:0] frame_q, rsh_q;
  logic [71:0] ux_q;
  logic [1:0] car_s_q, rxc_s_q;
  logic car_d_q, rdone_q, csr_wait_q;
  logic tod_v_q, sync_v_q, rx_pps_q, csr_req_q, csr_we_q;
  logic [15:0] csr_addr_q;
  logic [71:0] csr_wdata_q;
  logic rsym_v, tx_rise, setup, acc, wr, rd, pps_in;
  cfc_sym_e rsym, tsym;
  logic enc_en, dec_en, master;
  logic [87:0] pay_d;
  logic [22:0] hdr_d;
  logic [7:0] ulast;
  assign enc_en = ctrl_q[0];
  assign dec_en = ctrl_q[1];
  assign master = ctrl_q[2];
  assign setup = psel & ~penable & ~pready_q;
  assign acc = psel & penable & pready_q;
  assign wr = ce & acc & pwrite & ~pslverr_q;
  assign rd = ce & acc & ~pwrite & ~pslverr_q;
  assign tx_rise = car_s_q[1] & ~car_d_q;
  assign un = cfc_min9(ulen_q - usent_q);
  // Ninth byte of a user frame is fetched in the build cycle itself
  assign ulast = (lcnt_q < un) ? utx_mem[7'(usent_q + 8'(lcnt_q))] : 8'h00;
  // ============================================================
  // Pin synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      car_s_q <= 2'h0;
      car_d_q <= 1'b0;
      rxc_s_q <= 2'h0;
    end else if (ce) begin
      car_s_q <= {car_s_q[0], carrier_in};
      car_d_q <= car_s_q[1];
      rxc_s_q <= {rxc_s_q[0], pwm_rx_in};
    end
  end
  // ============================================================
  // APB answer, no wait state, unmapped addresses flag an error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (ce) begin
      pready_q <= setup;
      pslverr_q <= setup & ((paddr > `CFC_A_URX) | (paddr[1:0] != 2'h0));
      if (setup) begin
        case (paddr)
          `CFC_A_CTRL: prdata_q <= ctrl_q;
          `CFC_A_IDS: prdata_q <= {8'h00, ids_q};
          `CFC_A_TXP0: prdata_q <= txp_q[87:56];
          `CFC_A_TXP1: prdata_q <= txp_q[55:24];
          `CFC_A_TXP2: prdata_q <= {8'h00, txp_q[23:0]};
          `CFC_A_TXCMD: prdata_q <= {29'h0, cmd_q};
          `CFC_A_STAT: prdata_q <= {ucnt_q, 8'h00, usent_q, 3'h0, perr_q,
            rx_new_q, usr_pend_q, cmd_pend_q, st_q != CFC_TX_IDLE};
          `CFC_A_UTX: prdata_q <= {24'h0, ulen_q};
          `CFC_A_RXH: prdata_q <= {9'h000, rxh_q};
          `CFC_A_RXP0: prdata_q <= rxp_q[87:56];
          `CFC_A_RXP1: prdata_q <= rxp_q[55:24];
          `CFC_A_RXP2: prdata_q <= {8'h00, rxp_q[23:0]};
          `CFC_A_URX: prdata_q <= {23'h0, ucnt_q != 8'h00, urx_mem[urr_q]};
          default: prdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end
  // ============================================================
  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `CFC_CTRL_RST;
      ids_q <= `CFC_IDS_RST;
      txp_q <= 88'h0;
    end else if (wr) begin
      case (paddr)
        `CFC_A_CTRL: ctrl_q <= pwdata;
        `CFC_A_IDS: ids_q <= pwdata[23:0];
        `CFC_A_TXP0: txp_q[87:56] <= pwdata;
        `CFC_A_TXP1: txp_q[55:24] <= pwdata;
        `CFC_A_TXP2: txp_q[23:0] <= pwdata[23:0];
        default: ;
      endcase
    end
  end
  // ============================================================
  // master command request, held until framed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q <= `CFC_CMD_READ;
      cmd_pend_q <= 1'b0;
    end else if (ce) begin
      if (wr && paddr == `CFC_A_TXCMD && !cmd_pend_q) begin
        cmd_q <= pwdata[2:0];
        cmd_pend_q <= 1'b1;
      end else if (st_q == CFC_TX_LOAD && lcnt_q == 4'h8 &&
                   kind_q == CFC_K_CMD) begin
        cmd_pend_q <= 1'b0;
      end
    end
  end
  // ============================================================
  // second pulse from selected accumulator or divided output
  assign pps_in = ctrl_q[5] ? alt_second_pulse : second_pulse[ctrl_q[9:8]];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pps_pend_q <= 1'b0;
      pps_cnt_q <= 16'h0000;
      sync_pend_q <= 1'b0;
    end else if (ce) begin
      // latency from pulse to launch is counted
      if (pps_in && enc_en && ctrl_q[4]) begin
        pps_pend_q <= 1'b1;
        pps_cnt_q <= 16'h0000;
      end else begin
        if (pps_cnt_q != 16'hFFFF) pps_cnt_q <= pps_cnt_q + 16'h0001;
        if (st_q == CFC_TX_LOAD && lcnt_q == 4'h8 && kind_q == CFC_K_PPS)
          pps_pend_q <= 1'b0;
      end
      // sync frame requested by the selected DPLL
      if (sync_req && enc_en) sync_pend_q <= 1'b1;
      else if (st_q == CFC_TX_LOAD && lcnt_q == 4'h8 &&
               kind_q == CFC_K_SYNC) sync_pend_q <= 1'b0;
    end
  end
  // ============================================================
  // user transmit block, bit 8 of a write closes it
  always_ff @(posedge pclk) begin
    if (wr && paddr == `CFC_A_UTX && !usr_pend_q && ulen_q[7] == 1'b0)
      utx_mem[ulen_q[6:0]] <= pwdata[7:0];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ulen_q <= 8'h00;
      usent_q <= 8'h00;
      usr_pend_q <= 1'b0;
    end else if (ce) begin
      if (wr && paddr == `CFC_A_UTX && !usr_pend_q) begin
        if (ulen_q[7] == 1'b0) ulen_q <= ulen_q + 8'h01;
        if (pwdata[8]) usr_pend_q <= 1'b1;
      end else if (st_q == CFC_TX_LOAD && lcnt_q == 4'h8 &&
                   kind_q == CFC_K_USER) begin
        if (usent_q + 8'(un) >= ulen_q) begin
          usr_pend_q <= 1'b0;
          ulen_q <= 8'h00;
          usent_q <= 8'h00;
        end else begin
          usent_q <= usent_q + 8'(un);
        end
      end
    end
  end
  // ============================================================
  // Payload and header of the frame being built
  always_comb begin
    case (kind_q)
      CFC_K_PPS: pay_d = tod_value + 88'(pps_cnt_q) * 88'(`CFC_PCLK_NS);
      CFC_K_SYNC: pay_d = sync_data;
      CFC_K_CMD: pay_d = txp_q;
      CFC_K_REP: pay_d = rep_pay_q;
      CFC_K_USER: pay_d = {usent_q == 8'h00,
        7'(ulen_q - usent_q - 8'(un)), 4'h0, un, ubytes_q[63:0], ulast};
      default: pay_d = 88'h0;
    endcase
    case (kind_q)
      CFC_K_PPS: hdr_d[22:20] = `CFC_CMD_PPS;
      CFC_K_SYNC: hdr_d[22:20] = `CFC_CMD_SYNC;
      CFC_K_CMD: hdr_d[22:20] = cmd_q;
      CFC_K_REP: hdr_d[22:20] = rep_cmd_q;
      default: hdr_d[22:20] = `CFC_CMD_USER;
    endcase
    hdr_d[19:12] = ids_q[7:0];
    hdr_d[11] = master & ctrl_q[3] & (kind_q != CFC_K_REP);
    hdr_d[10:3] = (kind_q == CFC_K_REP) ? rep_dst_q : ids_q[23:16];
    hdr_d[2:0] = 3'h0;
  end
  // ============================================================
  // Encoder sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= CFC_TX_IDLE;
      kind_q <= CFC_K_PPS;
      lcnt_q <= 4'h0;
      bcnt_q <= 7'h00;
      frame_q <= 112'h0;
      ubytes_q <= 88'h0;
    end else if (ce) begin
      case (st_q)
        CFC_TX_IDLE: begin
          lcnt_q <= 4'h0;
          // all channels share the carrier by priority
          if (enc_en && (rep_pend_q | pps_pend_q | sync_pend_q |
                         cmd_pend_q | usr_pend_q)) begin
            st_q <= CFC_TX_LOAD;
            if (rep_pend_q) kind_q <= CFC_K_REP;
            else if (pps_pend_q) kind_q <= CFC_K_PPS;
            else if (sync_pend_q) kind_q <= CFC_K_SYNC;
            else if (cmd_pend_q) kind_q <= CFC_K_CMD;
            else kind_q <= CFC_K_USER;
          end
        end
        CFC_TX_LOAD: begin
          lcnt_q <= lcnt_q + 4'h1;
          ubytes_q <= {ubytes_q[79:0], ulast};
          if (lcnt_q == 4'h8) begin
            // parity makes the whole frame even
            frame_q <= {hdr_d, pay_d, ^{hdr_d, pay_d}};
            bcnt_q <= 7'h00;
            st_q <= CFC_TX_SEND;
          end
        end
        CFC_TX_SEND: begin
          if (tx_rise) begin
            frame_q <= {frame_q[110:0], 1'b0};
            bcnt_q <= bcnt_q + 7'h01;
            if (bcnt_q == 7'(`CFC_FRAME_BITS - 1)) st_q <= CFC_TX_IDLE;
          end
        end
        default: st_q <= CFC_TX_IDLE;
      endcase
    end
  end
  // space between frames, data symbols inside them
  assign tsym = (st_q != CFC_TX_SEND) ? CFC_SYM_SPACE :
                frame_q[111] ? CFC_SYM_ONE : CFC_SYM_ZERO;
  cfc_pwm_tx #(.CW(CW)) u_tx (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .rise(tx_rise),
    .sym(tsym),
    .pwm_q(pwm_out)
  );
  cfc_pwm_rx #(.CW(CW)) u_rx (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .lvl(rxc_s_q[1]),
    .sym_v_q(rsym_v),
    .sym_q(rsym)
  );
  // ============================================================
  // frame capture; a space inside a frame aborts it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsh_q <= 112'h0;
      rcnt_q <= 7'h00;
      rdone_q <= 1'b0;
    end else if (ce) begin
      rdone_q <= 1'b0;
      if (rsym_v) begin
        if (rsym == CFC_SYM_SPACE) begin
          rcnt_q <= 7'h00;
        end else begin
          rsh_q <= {rsh_q[110:0], rsym == CFC_SYM_ONE};
          rcnt_q <= rcnt_q + 7'h01;
          if (rcnt_q == 7'(`CFC_FRAME_BITS - 1)) begin
            rcnt_q <= 7'h00;
            rdone_q <= 1'b1;
          end
        end
      end
    end
  end
  // ============================================================
  // Received frame dispatch
  logic rx_hit;
  assign rx_hit = rdone_q & dec_en & ~(^rsh_q) &
    (rsh_q[`CFC_F_BC] | rsh_q[`CFC_F_DST] == ids_q[15:8]);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_data_q <= 88'h0;
      tod_v_q <= 1'b0;
      sync_v_q <= 1'b0;
      rx_pps_q <= 1'b0;
      rxh_q <= 23'h0;
      rxp_q <= 88'h0;
      rx_new_q <= 1'b0;
      perr_q <= 1'b0;
    end else if (ce) begin
      tod_v_q <= 1'b0;
      sync_v_q <= 1'b0;
      rx_pps_q <= 1'b0;
      if (rx_hit) begin
        rxh_q <= rsh_q[111:89];
        rxp_q <= rsh_q[`CFC_F_PAY];
        rx_data_q <= rsh_q[`CFC_F_PAY];
        // time frame loads accumulator, optional pulse
        if (rsh_q[`CFC_F_CMD] == `CFC_CMD_PPS) begin
          tod_v_q <= 1'b1;
          rx_pps_q <= ctrl_q[6];
        end
        // sync data to the selected DPLL
        if (rsh_q[`CFC_F_CMD] == `CFC_CMD_SYNC) sync_v_q <= 1'b1;
      end
      // Sticky flags; a new event wins over a clear
      if (rx_hit) rx_new_q <= 1'b1;
      else if (wr && paddr == `CFC_A_STAT && pwdata[3]) rx_new_q <= 1'b0;
      if (rdone_q && (^rsh_q)) perr_q <= 1'b1;
      else if (wr && paddr == `CFC_A_STAT && pwdata[4]) perr_q <= 1'b0;
    end
  end
  // ============================================================
  // remote access served locally, reply queued
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      csr_req_q <= 1'b0;
      csr_we_q <= 1'b0;
      csr_addr_q <= 16'h0000;
      csr_wdata_q <= 72'h0;
      csr_wait_q <= 1'b0;
      rep_pend_q <= 1'b0;
      rep_pay_q <= 88'h0;
      rep_cmd_q <= `CFC_CMD_READ;
      rep_dst_q <= 8'h00;
    end else if (ce) begin
      csr_req_q <= 1'b0;
      if (rx_hit && !master && !csr_wait_q && !rep_pend_q &&
          (rsh_q[`CFC_F_CMD] == `CFC_CMD_READ ||
           rsh_q[`CFC_F_CMD] == `CFC_CMD_WRITE)) begin
        csr_req_q <= 1'b1;
        csr_wait_q <= 1'b1;
        csr_we_q <= rsh_q[`CFC_F_CMD] == `CFC_CMD_WRITE;
        csr_addr_q <= rsh_q[88:73];
        csr_wdata_q <= rsh_q[72:1];
        rep_cmd_q <= rsh_q[`CFC_F_CMD];
        rep_dst_q <= rsh_q[`CFC_F_SRC];
      end else if (csr_wait_q && csr_ack) begin
        csr_wait_q <= 1'b0;
        rep_pend_q <= 1'b1;
        rep_pay_q <= {csr_addr_q, csr_we_q ? 72'h0 : csr_rdata};
      end else if (st_q == CFC_TX_LOAD && lcnt_q == 4'h8 &&
                   kind_q == CFC_K_REP) begin
        rep_pend_q <= 1'b0;
      end
    end
  end
  // ============================================================
  // user receive FIFO, one byte per cycle
  always_ff @(posedge pclk) begin
    if (ce && ux_k_q < ux_n_q && ucnt_q[7] == 1'b0)
      urx_mem[urw_q] <= ux_q[71:64];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ux_q <= 72'h0;
      ux_n_q <= 4'h0;
      ux_k_q <= 4'h0;
      urw_q <= 7'h00;
      urr_q <= 7'h00;
      ucnt_q <= 8'h00;
    end else if (ce) begin
      if (rx_hit && rsh_q[`CFC_F_CMD] == `CFC_CMD_USER) begin
        ux_q <= rsh_q[72:1];
        ux_n_q <= cfc_min9(rsh_q[80:73]);
        ux_k_q <= 4'h0;
      end else if (ux_k_q < ux_n_q) begin
        ux_q <= {ux_q[63:0], 8'h00};
        ux_k_q <= ux_k_q + 4'h1;
      end
      // Bytes beyond a full FIFO are dropped, nobody acknowledges
      if (ux_k_q < ux_n_q && ucnt_q[7] == 1'b0) urw_q <= urw_q + 7'h01;
      if (rd && paddr == `CFC_A_URX && ucnt_q != 8'h00)
        urr_q <= urr_q + 7'h01;
      ucnt_q <= ucnt_q
        + 8'(ux_k_q < ux_n_q && ucnt_q[7] == 1'b0)
        - 8'(rd && paddr == `CFC_A_URX && ucnt_q != 8'h00);
    end
  end
  // ============================================================
  // Registered outputs
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign tod_src_sel = ctrl_q[9:8];
  assign tod_load_sel = ctrl_q[11:10];
  assign sync_src_sel = ctrl_q[14:12];
  assign sync_load_sel = ctrl_q[18:16];
  assign rx_data = rx_data_q;
  assign tod_load_valid = tod_v_q;
  assign sync_load_valid = sync_v_q;
  assign rx_second_pulse = rx_pps_q;
  assign csr_req = csr_req_q;
  assign csr_we = csr_we_q;
  assign csr_addr = csr_addr_q;
  assign csr_wdata = csr_wdata_q;
endmodule : cfc_top

// [test/cfc_chk.sv]
`timescale 1ns/1ps
module cfc_chk (
  // APB side
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Link and pulses
  input wire logic carrier_in,
  input wire logic pwm_out,
  input wire logic tod_load_valid,
  input wire logic rx_second_pulse,
  input wire logic sync_load_valid,
  input wire logic csr_req
);
  // ====
  // Port checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  AST_RDY: assert property (psel && !penable |=> pready && penable)
    else $error("no answer after setup");
  AST_RDY1: assert property (pready |=> !pready)
    else $error("pready too long");
  AST_ERR: assert property (pslverr |-> pready)
    else $error("stray pslverr");
  AST_MAP: assert property (pready && paddr > 8'h30 |-> pslverr)
    else $error("unmapped not refused");
  AST_RISE: assert property ($rose(pwm_out) |-> carrier_in)
    else $error("pwm rise off carrier");
  AST_SEC: assert property (rx_second_pulse |-> tod_load_valid)
    else $error("second pulse alone");
  AST_SYNC: assert property (sync_load_valid |=> !sync_load_valid)
    else $error("sync pulse too long");
  AST_CSR: assert property (csr_req |=> !csr_req)
    else $error("csr_req too long");
endmodule : cfc_chk
bind cfc_top cfc_chk i_cfc_chk (.pclk, .presetn, .paddr, .psel, .penable,
  .pready, .pslverr, .carrier_in, .pwm_out, .tod_load_valid,
  .rx_second_pulse, .sync_load_valid, .csr_req);

// [test/cfc_peer.sv]
`timescale 1ns/1ps
module cfc_peer (
  // Carrier and link
  output logic carrier,
  input wire logic pwm_in,
  output logic pwm_back
);
  initial begin
    carrier = 1'b0;
    forever #62.5 carrier = ~carrier;
  end
  assign pwm_back = pwm_in;
endmodule : cfc_peer

// [test/tb_cfc_top.sv]
`timescale 1ns/1ps
`include "cfc_cfg.svh"
module tb_cfc_top;
  import cfc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, car, pwm;
  logic rxp, sreq, tlv, slv, creq, cwe, cack, rerr, rsp;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] spl;
  logic [87:0] time_of_day, sdat, rxd;
  logic [71:0] cwd;
  logic [15:0] cad;
  int err_count = 0;
  int n_tests = 0;
  cfc_top #(.CW(16)) i_cfc_top (.pclk, .presetn, .ce(1'b1), .paddr, .psel,
    .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .carrier_in(car), .pwm_out(pwm), .pwm_rx_in(rxp), .second_pulse(spl),
    .alt_second_pulse(1'b0), .tod_value(time_of_day), .tod_src_sel(),
    .sync_req(sreq), .sync_data(sdat), .sync_src_sel(), .rx_data(rxd),
    .tod_load_valid(tlv), .tod_load_sel(), .sync_load_valid(slv),
    .sync_load_sel(), .rx_second_pulse(rsp), .csr_req(creq), .csr_we(cwe),
    .csr_addr(cad), .csr_wdata(cwd), .csr_ack(cack), .csr_rdata(72'h0));
  cfc_peer i_cfc_peer (.carrier(car), .pwm_in(pwm), .pwm_back(rxp));
  // ====
  // Shared tasks
  task automatic chk(input logic [95:0] s, input logic [95:0] e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("mismatch at %0t: got %h want %h", $time, s, e);
    end
  endtask : chk
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    rerr = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic finish_test;
    $display("tests %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  // Clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // Watchdog, well beyond four frame times
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    finish_test();
  end
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {spl, sreq, cack, time_of_day, sdat} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `CFC_A_CTRL, 32'h0);
    chk(rd, `CFC_CTRL_RST);
    apb(1'b0, `CFC_A_IDS, 32'h0);
    chk(rd, `CFC_IDS_RST);
    apb(1'b0, 8'h34, 32'h0);
    chk({rerr, rd}, 33'h1_0000_0000);
    apb(1'b1, `CFC_A_IDS, 32'h003C_3C5A);
    apb(1'b1, `CFC_A_CTRL, 32'h0000_0053);
    $display("registers done");
    // Time frame looped back; low bytes absorb the offset
    {spl, time_of_day} <= {4'h1, 88'hA1B2_C3D4_E5F6_0718_2900_00};
    @(posedge pclk);
    spl <= 4'h0;
    @(posedge pclk iff tlv);
    chk(rsp, 1'b1);
    @(negedge pclk);
    chk(rxd[87:24], time_of_day[87:24]);
    chk(rxd[23:0] > time_of_day[23:0], 1'b1);
    apb(1'b0, `CFC_A_RXH, 32'h0);
    chk(rd, {12'h0, 8'h5A, 1'b0, 8'h3C, 3'h0});
    $display("time frame done");
    {sreq, sdat} <= {1'b1, 88'h0123_4567_89AB_CDEF_0246_8A};
    @(posedge pclk);
    sreq <= 1'b0;
    @(posedge pclk iff slv);
    @(negedge pclk);
    chk(rxd, sdat);
    $display("sync frame done");
    apb(1'b1, `CFC_A_TXP0, 32'hBEEF_1122);
    apb(1'b1, `CFC_A_TXP1, 32'h3344_5566);
    apb(1'b1, `CFC_A_TXP2, 32'h0077_8899);
    apb(1'b1, `CFC_A_TXCMD, 32'(`CFC_CMD_WRITE));
    @(posedge pclk iff creq);
    @(negedge pclk);
    chk({cwe, cad, cwd}, {1'b1, 88'hBEEF_1122_3344_5566_7788_99});
    @(posedge pclk);
    cack <= 1'b1;
    @(posedge pclk);
    cack <= 1'b0;
    // Reply goes to the requester id, so it must not be taken here
    repeat (2600) @(posedge pclk) chk(creq, 1'b0);
    $display("write frame done");
    // Two-byte user block looped back into the receive FIFO
    apb(1'b1, `CFC_A_UTX, 32'h0000_00A5);
    apb(1'b1, `CFC_A_UTX, 32'h0000_01C3);
    repeat (2200) @(posedge pclk);
    apb(1'b0, `CFC_A_RXP0, 32'h0);
    chk(rd, 32'h8002_A5C3);
    apb(1'b0, `CFC_A_URX, 32'h0);
    chk(rd, 32'h0000_01A5);
    apb(1'b0, `CFC_A_URX, 32'h0);
    chk(rd, 32'h0000_01C3);
    $display("user frame done");
    finish_test();
  end
endmodule : tb_cfc_top
